// >>> core/pilu_top.v
`timescale 1ns/100ps
`include "pilu_regs.vh"

module pilu_top (
  // clock and reset
  input wire I_CLOCK,
  input wire I_SRST,
  // register port
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // source requests, one-cycle pulses
  input wire [15:2] I_IRQ,
  input wire [2:0] I_IRQ_ALT,
  // instruction traps from the core, level while pending
  input wire I_SWTRAP,
  input wire I_ILLOP,
  // core handshake
  input wire I_ACK,
  input wire I_RETURN_FROM_IRQ,
  input wire I_RETURN_FROM_IRQ_IMF,
  output reg O_IRQ_REQ,
  output reg [15:0] O_VECTOR,
  output reg [3:0] O_SRC_ID,
  output reg O_IMF,
  output reg O_IMF_SAVED,
  // malfunction reset request
  output reg O_RESET_REQ
);

  // master and source enables
  reg master_enable_flag_reg;
  reg master_enable_flag_next;
  reg [15:4] source_enable_flag_reg;
  reg [15:4] source_enable_flag_next;
  // source selector and output selects
  reg [3:0] source_selector_reg;
  reg [3:0] source_selector_next;
  reg trap_output_select_reg;
  reg trap_output_select_next;
  reg wdog_output_select_reg;
  reg wdog_output_select_next;

  // latch bank signals
  wire [15:2] pending_latch;
  reg [15:2] latch_set;
  reg [15:2] sw_clr;
  reg [15:2] ack_clr;
  wire [15:2] latch_clr;
  reg [15:2] pend_view;
  reg [15:2] accept_ok;

  // arbitration result
  reg pick_valid;
  reg [3:0] pick_id;
  reg [15:0] pick_vec;
  // one loop index per process, so no variable has two drivers
  integer k_ack;
  integer k_ok;
  integer k_pick;

  // chosen request of each shared level
  wire lvl9_req;
  wire lvl14_req;
  wire lvl15_req;

  // next values of the registered read data and reset request
  reg [7:0] rdata_next;
  reg reset_req_next;

  // reset image of the two output selects, one bit per trap source
  localparam [1:0] RST_OUTSEL = `PILU_RST_OUTSEL;

  // register decode
  wire wr_en_lo;
  wire wr_en_hi;
  wire wr_latch_lo;
  wire wr_latch_hi;
  wire wr_sel;
  wire wr_outsel;

  assign wr_en_lo = I_WR && (I_ADDR == `PILU_ADDR_EN_LO);
  assign wr_en_hi = I_WR && (I_ADDR == `PILU_ADDR_EN_HI);
  assign wr_latch_lo = I_WR && (I_ADDR == `PILU_ADDR_LATCH_LO);
  assign wr_latch_hi = I_WR && (I_ADDR == `PILU_ADDR_LATCH_HI);
  assign wr_sel = I_WR && (I_ADDR == `PILU_ADDR_SEL);
  assign wr_outsel = I_WR && (I_ADDR == `PILU_ADDR_OUTSEL);

  // a select bit at one takes the second source; the unselected source
  // is dropped, not queued, so software must pick before enabling
  assign lvl9_req = source_selector_reg[`PILU_SEL_LEVEL9] ? I_IRQ_ALT[0] :
    I_IRQ[`PILU_LATCH_LVL9];
  assign lvl14_req = source_selector_reg[`PILU_SEL_LEVEL14] ?
    I_IRQ_ALT[1] : I_IRQ[`PILU_LATCH_LVL14];
  assign lvl15_req = source_selector_reg[`PILU_SEL_LEVEL15] ?
    I_IRQ_ALT[2] : I_IRQ[`PILU_LATCH_LVL15];

  // route each source to its latch; with the two traps, nineteen sources
  always @*
  begin
    latch_set = I_IRQ;
    latch_set[`PILU_LATCH_LVL9] = lvl9_req;
    latch_set[`PILU_LATCH_LVL14] = lvl14_req;
    latch_set[`PILU_LATCH_LVL15] = lvl15_req;
    // traps routed to reset never reach their latch
    latch_set[`PILU_LATCH_TRAP] = I_IRQ[`PILU_LATCH_TRAP] &
      ~trap_output_select_reg;
    latch_set[`PILU_LATCH_WDOG] = I_IRQ[`PILU_LATCH_WDOG] &
      ~wdog_output_select_reg;
  end

  // software clear: a zero bit clears, a one leaves the latch alone
  always @*
  begin
    sw_clr = 14'h0000;
    if (wr_latch_lo)
      sw_clr[7:2] = ~I_WDATA[7:2];
    if (wr_latch_hi)
      sw_clr[15:8] = ~I_WDATA;
  end

  // acceptance clears the latch of the source the core took
  always @*
  begin
    ack_clr = 14'h0000;
    for (k_ack = 2; k_ack <= 15; k_ack = k_ack + 1)
    begin
      if (I_ACK && (O_SRC_ID == k_ack[3:0]))
        ack_clr[k_ack] = 1'b1;
    end
  end

  assign latch_clr = sw_clr | ack_clr;

  // request latches 15 down to 2; bits 0 and 1 do not exist
  pilu_latch #(
    .WIDTH(14)
  ) u_latch (
    .clk(I_CLOCK),
    .srst(I_SRST),
    .set(latch_set),
    .clr(latch_clr),
    .q(pending_latch)
  );

  // master enable: acceptance stacks and clears, return restores
  always @*
  begin
    master_enable_flag_next = master_enable_flag_reg;
    if (I_ACK)
      master_enable_flag_next = 1'b0;
    else if (I_RETURN_FROM_IRQ)
      master_enable_flag_next = I_RETURN_FROM_IRQ_IMF;
    else if (wr_en_lo)
      master_enable_flag_next = I_WDATA[`PILU_MASTER_BIT];
  end

  // view the latches as they stand after this edge, so an accepted
  // source does not linger one extra cycle on the request output
  always @*
  begin
    pend_view = pending_latch & ~ack_clr;
    accept_ok[`PILU_LATCH_TRAP] = 1'b1;
    accept_ok[`PILU_LATCH_WDOG] = 1'b1;
    for (k_ok = 4; k_ok <= 15; k_ok = k_ok + 1)
      accept_ok[k_ok] = master_enable_flag_next &
        source_enable_flag_reg[k_ok];
    accept_ok[`PILU_LATCH_EXT0] = master_enable_flag_next &
      source_enable_flag_reg[`PILU_LATCH_EXT0] &
      source_selector_reg[`PILU_SEL_EXT0_EN];
  end

  // fixed priority: lowest latch number wins, non-maskables first
  always @*
  begin
    pick_valid = 1'b0;
    pick_id = `PILU_SRC_NOLATCH;
    for (k_pick = 15; k_pick >= 2; k_pick = k_pick - 1)
    begin
      if (pend_view[k_pick] && accept_ok[k_pick])
      begin
        pick_valid = 1'b1;
        pick_id = k_pick[3:0];
      end
    end
    // traps from instructions share rank 2 and carry no latch
    if ((I_SWTRAP || I_ILLOP) && !I_ACK)
    begin
      pick_valid = 1'b1;
      pick_id = `PILU_SRC_NOLATCH;
    end
  end

  // vectors step down by two per latch number from the top
  always @*
  begin
    if (pick_id == `PILU_SRC_NOLATCH)
      pick_vec = `PILU_VEC_SWTRAP;
    else
      pick_vec = `PILU_VEC_TOP - {11'h000, pick_id, 1'b0};
  end

  // core-facing outputs are registered; reset shows the reset vector
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_IRQ_REQ <= 1'b0;
      O_VECTOR <= `PILU_VEC_RESET;
      O_SRC_ID <= `PILU_SRC_NOLATCH;
    end
    else
    begin
      O_IRQ_REQ <= pick_valid;
      O_VECTOR <= pick_vec;
      O_SRC_ID <= pick_id;
    end
  end

  // master enable and its stacked copy
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      master_enable_flag_reg <= `PILU_RST_MASTER;
      O_IMF <= `PILU_RST_MASTER;
      O_IMF_SAVED <= 1'b0;
    end
    else
    begin
      master_enable_flag_reg <= master_enable_flag_next;
      O_IMF <= master_enable_flag_next;
      if (I_ACK)
        O_IMF_SAVED <= master_enable_flag_reg;
    end
  end

  // individual source enables; the low byte shares its address with
  // the master flag, so one write loads both fields
  always @*
  begin
    source_enable_flag_next = source_enable_flag_reg;
    if (wr_en_lo)
      source_enable_flag_next[7:4] = I_WDATA[7:4];
    if (wr_en_hi)
      source_enable_flag_next[15:8] = I_WDATA;
  end

  // enables take their new value at the write edge
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      source_enable_flag_reg <= `PILU_RST_ENABLES;
    else
      source_enable_flag_reg <= source_enable_flag_next;
  end

  // selector and output selects follow their own addresses
  always @*
  begin
    source_selector_next = source_selector_reg;
    trap_output_select_next = trap_output_select_reg;
    wdog_output_select_next = wdog_output_select_reg;
    if (wr_sel)
      source_selector_next = I_WDATA[3:0];
    if (wr_outsel)
    begin
      trap_output_select_next = I_WDATA[`PILU_OUTSEL_TRAP];
      wdog_output_select_next = I_WDATA[`PILU_OUTSEL_WDOG];
    end
  end

  // both output selects wake up in reset mode, so a trap resets the
  // chip until software deliberately routes it to an interrupt
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      source_selector_reg <= `PILU_RST_SEL;
      trap_output_select_reg <= RST_OUTSEL[`PILU_OUTSEL_TRAP];
      wdog_output_select_reg <= RST_OUTSEL[`PILU_OUTSEL_WDOG];
    end
    else
    begin
      source_selector_reg <= source_selector_next;
      trap_output_select_reg <= trap_output_select_next;
      wdog_output_select_reg <= wdog_output_select_next;
    end
  end

  // a trap in reset mode bypasses its latch and asks for a reset
  always @*
  begin
    reset_req_next = 1'b0;
    if (I_IRQ[`PILU_LATCH_TRAP] && trap_output_select_reg)
      reset_req_next = 1'b1;
    if (I_IRQ[`PILU_LATCH_WDOG] && wdog_output_select_reg)
      reset_req_next = 1'b1;
  end

  // registered one-cycle reset request, free of decode glitches
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      O_RESET_REQ <= 1'b0;
    else
      O_RESET_REQ <= reset_req_next;
  end

  // read mux; idle cycles and unmapped addresses give zero, so stale
  // data from an earlier read never lingers on the bus
  always @*
  begin
    rdata_next = 8'h00;
    if (I_RD)
    begin
      case (I_ADDR)
        `PILU_ADDR_EN_LO:
          rdata_next = {source_enable_flag_reg[7:4], 3'h0,
            master_enable_flag_reg};
        `PILU_ADDR_EN_HI:
          rdata_next = source_enable_flag_reg[15:8];
        `PILU_ADDR_LATCH_LO:
          rdata_next = {pending_latch[7:2], 2'h0};
        `PILU_ADDR_LATCH_HI:
          rdata_next = pending_latch[15:8];
        `PILU_ADDR_SEL:
          rdata_next = {4'h0, source_selector_reg};
        `PILU_ADDR_OUTSEL:
          rdata_next = {6'h00, wdog_output_select_reg,
            trap_output_select_reg};
        default:
          rdata_next = 8'h00;
      endcase
    end
  end

  // read data one cycle after the strobe
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      O_RDATA <= 8'h00;
    else
      O_RDATA <= rdata_next;
  end

endmodule // pilu_top

// >>> core/pilu_regs.vh
// What this block does
// - nineteen sources, three levels shared by two
// - request sets latch; enabled latch asks CPU
// - maskables need master and own enable
// - fixed priority: reset, non-maskables, levels 4-15
// - software trap and illegal opcode share one rank
// - software trap, illegal opcode: no latch, FFFC
// - fetch trap uses latch 2, vector FFFA
// - watchdog uses latch 3, vector FFF8
// - level vectors FFF6 down to FFE0; reset FFFE
// - external line 0 also needs pin enable
// - select bit picks first or second source
// - every other source owns one latch
// - latch clears when CPU accepts it
// - reset clears all latches
// - latches at 3C/3D; zero write clears bit
// - writing one never sets a latch
// - latch reads show pending state
// - master enable already zero in handler
// - acceptance stacks master enable then clears it
// - master enable is bit 0 at 3A, resets zero
// - source enables 15-4 reset zero
`ifndef PILU_REGS_VH
`define PILU_REGS_VH

// register byte addresses
`define PILU_ADDR_EN_LO 8'h3a
`define PILU_ADDR_EN_HI 8'h3b
`define PILU_ADDR_LATCH_LO 8'h3c
`define PILU_ADDR_LATCH_HI 8'h3d
`define PILU_ADDR_SEL 8'h3e
`define PILU_ADDR_OUTSEL 8'h3f

// field positions
`define PILU_MASTER_BIT 0
`define PILU_SEL_LEVEL9 0
`define PILU_SEL_LEVEL14 1
`define PILU_SEL_LEVEL15 2
`define PILU_SEL_EXT0_EN 3
`define PILU_OUTSEL_TRAP 0
`define PILU_OUTSEL_WDOG 1

// latch numbers
`define PILU_LATCH_TRAP 2
`define PILU_LATCH_WDOG 3
`define PILU_LATCH_EXT0 4
`define PILU_LATCH_LVL9 9
`define PILU_LATCH_LVL14 14
`define PILU_LATCH_LVL15 15
`define PILU_SRC_NOLATCH 4'h0

// vectors
`define PILU_VEC_RESET 16'hfffe
`define PILU_VEC_TOP 16'hfffe
`define PILU_VEC_SWTRAP 16'hfffc

// reset values
`define PILU_RST_MASTER 1'b0
`define PILU_RST_ENABLES 12'h000
`define PILU_RST_SEL 4'h0
`define PILU_RST_OUTSEL 2'h3

`endif

// >>> core/pilu_latch.v
`timescale 1ns/100ps
// one bank of request latches; a set beats a clear in the same cycle
module pilu_latch #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // controls
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  // state
  output reg [WIDTH-1:0] q
);

  // reset zero, set wins over clear so no request is lost
  always @(posedge clk)
  begin
    if (srst)
      q <= {WIDTH{1'b0}};
    else
      q <= set | (q & ~clr);
  end

endmodule // pilu_latch

// >>> tb/pilu_checker_asserts.sv
`timescale 1ns/100ps
// watches the top ports for the acceptance rules
module pilu_checker (
  // clock and reset
  input wire I_CLOCK,
  input wire I_SRST,
  // core and bus inputs
  input wire I_RD,
  input wire I_ACK,
  input wire I_RETURN_FROM_IRQ,
  input wire I_RETURN_FROM_IRQ_IMF,
  input wire I_SWTRAP,
  input wire I_ILLOP,
  // outputs
  input wire [7:0] O_RDATA,
  input wire O_IRQ_REQ,
  input wire [15:0] O_VECTOR,
  input wire [3:0] O_SRC_ID,
  input wire O_IMF,
  input wire O_IMF_SAVED
);
  default clocking dc @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);

  a_reset_state: assert property (
    $fell(I_SRST) |-> !O_IRQ_REQ && !O_IMF && O_VECTOR == 16'hfffe)
    else $error("bad state after reset");
  a_rdata_idle: assert property (
    !I_RD |=> O_RDATA == 8'h00)
    else $error("read data not idle");
  a_vector_map: assert property (
    O_IRQ_REQ |-> O_VECTOR == (O_SRC_ID == 4'h0 ? 16'hfffc :
      16'hfffe - {11'h000, O_SRC_ID, 1'b0}))
    else $error("vector mismatch");
  a_mask_gate: assert property (
    O_IRQ_REQ && O_SRC_ID > 4'h3 |-> O_IMF)
    else $error("maskable with master off");
  a_ack_stacks: assert property (
    I_ACK |=> !O_IMF && O_IMF_SAVED == $past(O_IMF))
    else $error("master not stacked");
  a_handler_masked: assert property (
    I_ACK |=> !(O_IRQ_REQ && O_SRC_ID > 4'h3))
    else $error("maskable after accept");
  a_return_from_irq_restore: assert property (
    I_RETURN_FROM_IRQ && !I_ACK |=> O_IMF == $past(I_RETURN_FROM_IRQ_IMF))
    else $error("master not restored");
  a_trap_shown: assert property (
    ((I_SWTRAP || I_ILLOP) && !I_ACK) [*2] |=> O_IRQ_REQ &&
      O_SRC_ID == 4'h0)
    else $error("trap not shown");
endmodule // pilu_checker

bind pilu_top pilu_checker chk (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
  .I_RD(I_RD), .I_ACK(I_ACK), .I_RETURN_FROM_IRQ(I_RETURN_FROM_IRQ), .I_RETURN_FROM_IRQ_IMF(I_RETURN_FROM_IRQ_IMF),
  .I_SWTRAP(I_SWTRAP), .I_ILLOP(I_ILLOP), .O_RDATA(O_RDATA),
  .O_IRQ_REQ(O_IRQ_REQ), .O_VECTOR(O_VECTOR), .O_SRC_ID(O_SRC_ID),
  .O_IMF(O_IMF), .O_IMF_SAVED(O_IMF_SAVED));

// >>> tb/pilu_core_model.sv
`timescale 1ns/100ps
// core stand-in: accepts after a lag, returns after another
module pilu_core_model (
  // clock, reset and pacing
  input wire clk,
  input wire srst,
  input wire [2:0] lag,
  // from the controller
  input wire req,
  input wire imf_saved,
  // to the controller
  output reg ack,
  output reg return_from_irq,
  output reg return_from_irq_imf
);
  reg [3:0] cnt_reg;
  reg busy_reg;

  // one handler at a time, so nesting is never exercised here
  always @(posedge clk)
  begin
    ack <= 1'b0;
    return_from_irq <= 1'b0;
    cnt_reg <= (busy_reg || req) ? cnt_reg + 4'h1 : 4'h0;
    if (srst)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      return_from_irq_imf <= 1'b0;
    end
    else if (cnt_reg > {1'b0, lag} && (busy_reg || req))
    begin
      ack <= !busy_reg;
      return_from_irq <= busy_reg;
      return_from_irq_imf <= imf_saved;
      busy_reg <= !busy_reg;
      cnt_reg <= 4'h0;
    end
  end
endmodule // pilu_core_model

// >>> tb/pilu_bench.sv
`timescale 1ns/100ps
module prioritized_interrupt_latch_unit_bench;
  reg clk, srst, wr, rd, swtrap, illop;
  reg [7:0] addr, wdata;
  reg [15:2] irq, msk;
  reg [2:0] alt, lag, am;
  reg [3:0] sel;
  reg [15:0] e, p, acc;
  wire ack, return_from_irq, return_from_irq_imf, req, master_enable_flag, imf_saved, reset_req;
  wire [7:0] rdata;
  wire [15:0] vector;
  wire [3:0] src_id;
  logic [3:0] acked [$];
  integer failures, checks_done, i, k, r, seen;

  pilu_top uut (.I_CLOCK(clk), .I_SRST(srst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_IRQ(irq),
    .I_IRQ_ALT(alt), .I_SWTRAP(swtrap), .I_ILLOP(illop), .I_ACK(ack),
    .I_RETURN_FROM_IRQ(return_from_irq), .I_RETURN_FROM_IRQ_IMF(return_from_irq_imf), .O_IRQ_REQ(req),
    .O_VECTOR(vector), .O_SRC_ID(src_id), .O_IMF(master_enable_flag),
    .O_IMF_SAVED(imf_saved), .O_RESET_REQ(reset_req));
  pilu_core_model core (.clk(clk), .srst(srst), .lag(lag), .req(req),
    .imf_saved(imf_saved), .ack(ack), .return_from_irq(return_from_irq), .return_from_irq_imf(return_from_irq_imf));

  // free-running clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input [15:0] x, input [15:0] got);
  begin
    checks_done = checks_done + 1;
    if (got !== x)
    begin
      failures = failures + 1;
      $display("unexpected %s: expected %h, seen %h", what, x, got);
    end
  end
  endtask

  // vector each source must carry: traps at the top, levels below
  function [15:0] vec_of(input [3:0] id);
  begin
    case (id)
      4'h0: vec_of = 16'hfffc;
      4'h2: vec_of = 16'hfffa;
      4'h3: vec_of = 16'hfff8;
      default: vec_of = 16'hfff6 - {11'h000, id - 4'h4, 1'b0};
    endcase
  end
  endfunction

  // log every source the core took and check the vector shown with it
  always @(posedge clk)
    if (ack === 1'b1)
    begin
      acked.push_back(src_id);
      chk("vector", vec_of(src_id), vector);
    end

  task tally_and_finish;
  begin
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  // bus cycles: strobe for one cycle, read data the cycle after
  task automatic put(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask
  task automatic get(input [7:0] a, input [7:0] x);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", {8'h00, x}, {8'h00, rdata});
  end
  endtask
  task automatic pulse(input [15:2] m, input [2:0] a);
  begin
    @(posedge clk);
    irq <= m;
    alt <= a;
    @(posedge clk);
    irq <= 14'h0000;
    alt <= 3'h0;
  end
  endtask
  // bounded wait; a hang ends the run through the report
  task automatic wait_acks(input integer n);
  begin
    k = 0;
    while (acked.size() < n && k < 500)
    begin
      @(posedge clk);
      #1 k = k + 1;
    end
    chk("accept count", n, acked.size());
    if (acked.size() < n)
      tally_and_finish;
  end
  endtask

  // latch a mix with master off, then let the core drain it in order
  task automatic round(input [3:0] s, input [15:2] m, input [2:0] a);
  begin
    repeat (20) @(posedge clk);
    put(8'h3a, {e[7:4], 4'h0});
    put(8'h3c, 8'h0c);
    put(8'h3d, 8'h00);
    put(8'h3e, {4'h0, s});
    put(8'h3b, e[15:8]);
    acked.delete();
    pulse(m, a);
    p = {m, 2'b00};
    p[9] = s[0] ? a[0] : m[9];
    p[14] = s[1] ? a[1] : m[14];
    p[15] = s[2] ? a[2] : m[15];
    acc = p & {e[15:5], e[4] & s[3], 4'h0};
    put(8'h3a, {e[7:4], 4'h1});
    wait_acks($countones(acc));
    k = 0;
    for (i = 4; i < 16; i = i + 1)
      if (acc[i])
      begin
        chk("accepted source", i[15:0], {12'h000, acked[k]});
        k = k + 1;
      end
    get(8'h3c, {p[7:2] & ~acc[7:2], 2'b00});
    get(8'h3d, p[15:8] & ~acc[15:8]);
  end
  endtask

  initial
  begin
    failures = 0;
    checks_done = 0;
    srst = 1'b1;
    {wr, rd, swtrap, illop} = 4'h0;
    {addr, wdata} = 16'h0000;
    {irq, alt, lag} = 20'h00000;
    void'($urandom(62026));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // reset values, an unmapped read, reserved enable bits
    for (i = 0; i < 6; i = i + 1)
      get(8'h3a + i[7:0], (i == 5) ? 8'h03 : 8'h00);
    get(8'h40, 8'h00);
    put(8'h3a, 8'hff);
    get(8'h3a, 8'hf1);
    put(8'h3a, 8'h00);
    // zero clears one latch, a one never sets
    pulse(14'h3ffc, 3'h7);
    k = $urandom;
    put(8'h3d, k[7:0]);
    put(8'h3c, 8'hff);
    get(8'h3d, k[7:0]);
    get(8'h3c, 8'hf0);
    put(8'h3c, 8'h0c);
    put(8'h3d, 8'h00);
    put(8'h3d, 8'hff);
    get(8'h3d, 8'h00);
    // trap and watchdog ask for reset until rerouted
    for (i = 0; i < 2; i = i + 1)
    begin
      pulse(i ? 14'h0002 : 14'h0001, 3'h0);
      seen = 0;
      repeat (3)
      begin
        #1 seen = seen | reset_req;
        @(posedge clk);
      end
      chk("reset request", 16'h0001, seen[15:0]);
    end
    get(8'h3c, 8'h00);
    put(8'h3f, 8'h00);
    acked.delete();
    pulse(14'h0003, 3'h0);
    wait_acks(2);
    chk("first nonmaskable", 16'h0002, {12'h000, acked[0]});
    chk("second nonmaskable", 16'h0003, {12'h000, acked[1]});
    // latch-less traps, held until the core accepts them
    for (i = 0; i < 2; i = i + 1)
    begin
      repeat (20) @(posedge clk);
      acked.delete();
      swtrap <= (i == 0);
      illop <= (i == 1);
      wait_acks(1);
      swtrap <= 1'b0;
      illop <= 1'b0;
      chk("trap source", 16'h0000, {12'h000, acked[0]});
    end
    // first sources, second sources, then random mixes
    for (r = 0; r < 8; r = r + 1)
    begin
      k = $urandom;
      lag <= k[2:0];
      e = (r < 2) ? 16'hfff0 : k[31:16];
      sel = (r == 0) ? 4'h8 : (r == 1) ? 4'hf : k[6:3];
      msk = (r == 0) ? 14'h3ffc : (r == 1) ? 14'h0f7c : k[13:0] & 14'h3ffc;
      am = (r < 2) ? 3'h7 : k[9:7];
      round(sel, msk, am);
    end
    tally_and_finish;
  end
endmodule // prioritized_interrupt_latch_unit_bench
